// file: mad_map.svh
// Constants of the multiply-add block: register offsets, field positions,
// reset values and select codes. Included by the stage register and the top module.
// Summary of operation
// - Each unit's A and B operands may be registered, on any clock and clear.
// - Each unit takes A, and B, from its own input or the shift-in path.
// - Each unit's product may be registered, on any clock and any clear or none.
// - Four clock inputs; any register may follow any one of them.
// - Four clear inputs; each zeroes its registers' outputs at once, and their contents at the next clk edge.
// - Each clock has an enable; its registers load only while it is high.
// - A sign input high treats A as two's complement, low as unsigned.
// - B sign input high treats B as two's complement, low as unsigned.
// - The result bus is as wide as the result-width parameter.
// - With saturation enabled, an overflow flag shows the saturated overflow.
// - The A and B scan chains may be brought out for cascading.
// - With a variable first pair, select high adds, low subtracts product two.
// - Operand widths may be set from 1 to 256 bits at build time.
`ifndef MAD_MAP_SVH
`define MAD_MAP_SVH
`define MAD_OFS_CTRL 4'h0
`define MAD_OFS_STAT 4'h4
`define MAD_OFS_MASK 4'h8
`define MAD_OFS_INFO 4'hc
`define MAD_CTRL_SAT 0
`define MAD_STAT_OVF 0
`define MAD_STAT_UPD 1
`define MAD_CTRL_RST 1'b1
`define MAD_MASK_RST 2'h0
`define MAD_ACLR_NONE 3'h7
`endif

// file: mad_pkg.sv
// Types shared by the multiply-add block.
// Assumes a SystemVerilog-2012 tool; holds no logic.
package mad_pkg;
  typedef enum logic [1:0] {
    MAD_BUS_IDLE = 2'b01,
    MAD_BUS_ACK = 2'b10
  } mad_bus_e;
  typedef enum logic [1:0] {
    MAD_DIR_ADD = 2'h0,
    MAD_DIR_SUB = 2'h1,
    MAD_DIR_VAR = 2'h2
  } mad_dir_e;
endpackage

// file: mad_ctl_if.sv
// Clock strobe, enable and clear bundle shared by every stage register.
// Assumes all members are driven from logic on clk.
`timescale 1ns/100ps
`default_nettype none
interface mad_ctl_if;
  logic [3:0] strobe;
  logic [3:0] ena;
  logic [3:0] clr;
  logic srst;
  modport src (output strobe, output ena, output clr, output srst);
  modport sink (input strobe, input ena, input clr, input srst);
endinterface
`default_nettype wire

// file: mad_mult.sv
// One product unit: sign extension by the sign controls, then a multiply.
// Assumes operands already aligned by any input registers.
`timescale 1ns/100ps
`default_nettype none
module mad_mult #(
  parameter int AW = 16,
  parameter int BW = 16
) (
  input wire logic [AW-1:0] a,
  input wire logic sa,
  input wire logic [BW-1:0] b,
  input wire logic sb,
  output logic signed [AW+BW+1:0] p
);
  logic signed [AW:0] ax;
  logic signed [BW:0] bx;
  // One guard bit lets signed and unsigned operands share one multiplier
  assign ax = {sa & a[AW-1], a};
  assign bx = {sb & b[BW-1], b};
  assign p = ax * bx;
endmodule // mad_mult
`default_nettype wire

// file: mad_stage_reg.sv
// Optional pipeline register with selectable clock strobe and clear.
// Assumes strobes, enables and clears come from logic on clk.
`timescale 1ns/100ps
`default_nettype none
`include "mad_map.svh"
module mad_stage_reg import mad_pkg::*; #(
  parameter int W = 8,
  parameter int EN = 1,
  parameter logic [1:0] CLK_SEL = 2'h0,
  parameter logic [2:0] CLR_SEL = `MAD_ACLR_NONE
) (
  input wire logic clk,
  mad_ctl_if.sink ctl,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] data;
  } mad_stage_s;
  mad_stage_s st_q;
  mad_stage_s st_d;
  logic clr;
  logic take;

  assign clr = (CLR_SEL == `MAD_ACLR_NONE) ? 1'b0 : ctl.clr[CLR_SEL[1:0]];
  assign take = ctl.strobe[CLK_SEL] & ctl.ena[CLK_SEL];

  always_comb begin
    st_d = st_q;
    if (ctl.srst || clr) begin
      st_d.data = '0;
    end else if (take) begin
      st_d.data = d;
    end
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  // Clear masks the output at once, not a clock later
  assign q = (EN == 0) ? d : (clr ? '0 : st_q.data);
endmodule // mad_stage_reg
`default_nettype wire

// file: mad_top.sv
// Multiply-add datapath with per-unit operand and product registers,
// saturation, scan chains and an Avalon-MM control and status slave.
// Assumes operands, strobes, enables and clears come from logic on clk.
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mad_map.svh"
module mad_top import mad_pkg::*; #(
  parameter int PRODUCT_UNIT_COUNT = 2,
  parameter int A_W = 16,
  parameter int B_W = 16,
  parameter int R_W = 32,
  parameter logic [3:0] IN_REG_A = 4'hf,
  parameter logic [3:0] IN_REG_B = 4'hf,
  parameter logic [3:0] SRC_A = 4'h0,
  parameter logic [3:0] SRC_B = 4'h0,
  parameter logic [3:0] PROD_REG = 4'hf,
  parameter logic [7:0] CLK_A = 8'h00,
  parameter logic [7:0] CLK_B = 8'h00,
  parameter logic [7:0] CLK_P = 8'h00,
  parameter logic [11:0] CLR_A = {4{`MAD_ACLR_NONE}},
  parameter logic [11:0] CLR_B = {4{`MAD_ACLR_NONE}},
  parameter logic [11:0] CLR_P = {4{`MAD_ACLR_NONE}},
  parameter logic [1:0] OUT_CLK = 2'h0,
  parameter logic [2:0] OUT_CLR = `MAD_ACLR_NONE,
  parameter mad_dir_e FIRST_DIR = MAD_DIR_ADD,
  parameter mad_dir_e SECOND_DIR = MAD_DIR_ADD,
  parameter int SAT_EN = 1,
  parameter int SCAN_EN = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [PRODUCT_UNIT_COUNT*A_W-1:0] op_a_bus,
  input wire logic [PRODUCT_UNIT_COUNT*B_W-1:0] op_b_bus,
  input wire logic [A_W-1:0] scan_in_a,
  input wire logic [B_W-1:0] scan_in_b,
  input wire logic [3:0] clock_strobe,
  input wire logic [3:0] clock_enable,
  input wire logic [3:0] async_clear,
  input wire logic operand_a_signed,
  input wire logic operand_b_signed,
  input wire logic first_pair_add_sub_sel,
  output logic [R_W-1:0] result,
  output logic overflow,
  output logic [A_W-1:0] scan_out_a,
  output logic [B_W-1:0] scan_out_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  localparam int N = PRODUCT_UNIT_COUNT;
  localparam int PW = A_W + B_W + 2;
  // Two spare bits cover a sum of up to four products
  localparam int SW = PW + 2;
  localparam int XW = SW + R_W;
  localparam logic [31:0] INFO = {8'(R_W - 1), 8'(B_W - 1), 8'(A_W - 1), 8'(N - 1)};

  typedef struct packed {
    mad_bus_e bus;
    logic ctrl_sat;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] rdata;
  } mad_csr_s;

  mad_csr_s st_q;
  mad_csr_s st_d;

  mad_ctl_if ctl ();

  logic [A_W-1:0] a_src [N];
  logic [A_W-1:0] a_op [N];
  logic [A_W-1:0] a_chain [N+1];
  logic [B_W-1:0] b_src [N];
  logic [B_W-1:0] b_op [N];
  logic [B_W-1:0] b_chain [N+1];
  logic signed [PW-1:0] p_raw [N];
  logic signed [PW-1:0] p_op [N];
  logic signed [SW-1:0] sum;
  logic [XW-1:0] sum_x;
  logic [R_W-1:0] pos_lim;
  logic [R_W-1:0] sat_val;
  logic [R_W-1:0] res_d;
  logic sat_on;
  logic fits;
  logic ovf_d;
  logic out_take;
  logic out_clr;
  logic [1:0] events;
  logic wr_ok;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic signed [SW-1:0] widen(input logic signed [PW-1:0] p);
    return {{2{p[PW-1]}}, p};
  endfunction

  function automatic logic unit_subtracts(input int i, input logic sel);
    if (i == 1) begin
      return (FIRST_DIR == MAD_DIR_SUB) || (FIRST_DIR == MAD_DIR_VAR && !sel);
    end
    if (i == 3) begin
      return SECOND_DIR == MAD_DIR_SUB;
    end
    return 1'b0;
  endfunction

  function automatic logic [31:0] reg_read(input logic [3:0] ofs, input mad_csr_s s);
    logic [31:0] v;
    v = '0;
    case (ofs)
      `MAD_OFS_CTRL: v[`MAD_CTRL_SAT] = s.ctrl_sat;
      `MAD_OFS_STAT: v[1:0] = s.stat;
      `MAD_OFS_MASK: v[1:0] = s.mask;
      `MAD_OFS_INFO: v = INFO;
      default: v = '0;
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Clock and clear bundle

  assign ctl.strobe = clock_strobe;
  assign ctl.ena = clock_enable;
  assign ctl.clr = async_clear;
  assign ctl.srst = srst;

  //////////////////////////////////////////////////////////////////////////
  // Product units

  // Unit 0 shifts in from the scan inputs, unit i from unit i-1
  assign a_chain[0] = scan_in_a;
  assign b_chain[0] = scan_in_b;

  for (genvar i = 0; i < N; i++) begin : g_unit
    // Operands packed unit 0 in the low bits
    assign a_src[i] = SRC_A[i] ? a_chain[i] : op_a_bus[i*A_W +: A_W];
    assign b_src[i] = SRC_B[i] ? b_chain[i] : op_b_bus[i*B_W +: B_W];

    mad_stage_reg #(
      .W(A_W),
      .EN(int'(IN_REG_A[i])),
      .CLK_SEL(CLK_A[2*i +: 2]),
      .CLR_SEL(CLR_A[3*i +: 3])
    ) u_reg_a (
      .clk(clk),
      .ctl(ctl),
      .d(a_src[i]),
      .q(a_op[i])
    );

    mad_stage_reg #(
      .W(B_W),
      .EN(int'(IN_REG_B[i])),
      .CLK_SEL(CLK_B[2*i +: 2]),
      .CLR_SEL(CLR_B[3*i +: 3])
    ) u_reg_b (
      .clk(clk),
      .ctl(ctl),
      .d(b_src[i]),
      .q(b_op[i])
    );

    assign a_chain[i+1] = a_op[i];
    assign b_chain[i+1] = b_op[i];

    mad_mult #(
      .AW(A_W),
      .BW(B_W)
    ) u_mult (
      .a(a_op[i]),
      .sa(operand_a_signed),
      .b(b_op[i]),
      .sb(operand_b_signed),
      .p(p_raw[i])
    );

    mad_stage_reg #(
      .W(PW),
      .EN(int'(PROD_REG[i])),
      .CLK_SEL(CLK_P[2*i +: 2]),
      .CLR_SEL(CLR_P[3*i +: 3])
    ) u_reg_p (
      .clk(clk),
      .ctl(ctl),
      .d(p_raw[i]),
      .q(p_op[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Adder and saturation

  always_comb begin
    sum = '0;
    for (int i = 0; i < N; i++) begin
      if (unit_subtracts(i, first_pair_add_sub_sel)) begin
        sum = sum - widen(p_op[i]);
      end else begin
        sum = sum + widen(p_op[i]);
      end
    end
  end

  assign sum_x = {{R_W{sum[SW-1]}}, sum};
  assign sat_on = (SAT_EN != 0) && st_q.ctrl_sat;
  assign fits = sum_x[XW-1:R_W-1] == {(SW+1){sum_x[XW-1]}};
  assign pos_lim = {R_W{1'b1}} >> 1;
  assign sat_val = sum[SW-1] ? ~pos_lim : pos_lim;
  // Without saturation the result wraps and no flag is raised
  assign ovf_d = sat_on && !fits;
  assign res_d = ovf_d ? sat_val : sum_x[R_W-1:0];

  // Output register is always built so result and flag come from flops
  mad_stage_reg #(
    .W(R_W + 1),
    .EN(1),
    .CLK_SEL(OUT_CLK),
    .CLR_SEL(OUT_CLR)
  ) u_reg_out (
    .clk(clk),
    .ctl(ctl),
    .d({ovf_d, res_d}),
    .q({overflow, result})
  );

  assign scan_out_a = (SCAN_EN != 0) ? a_op[N-1] : '0;
  assign scan_out_b = (SCAN_EN != 0) ? b_op[N-1] : '0;

  //////////////////////////////////////////////////////////////////////////
  // Control and status slave

  assign out_take = clock_strobe[OUT_CLK] & clock_enable[OUT_CLK];
  assign out_clr = (OUT_CLR != `MAD_ACLR_NONE) && async_clear[OUT_CLR[1:0]];
  assign events = {out_take, overflow};
  assign wr_ok = (st_q.bus == MAD_BUS_ACK) && avs_write && avs_byteenable[0];

  always_comb begin
    st_d = st_q;
    case (st_q.bus)
      MAD_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          st_d.bus = MAD_BUS_ACK;
          st_d.rdata = reg_read(avs_address, st_q);
        end
      end
      MAD_BUS_ACK: begin
        st_d.bus = MAD_BUS_IDLE;
      end
      default: begin
        st_d.bus = MAD_BUS_IDLE;
      end
    endcase
    if (wr_ok) begin
      case (avs_address)
        `MAD_OFS_CTRL: st_d.ctrl_sat = avs_writedata[`MAD_CTRL_SAT];
        `MAD_OFS_STAT: st_d.stat = st_q.stat & ~avs_writedata[1:0];
        `MAD_OFS_MASK: st_d.mask = avs_writedata[1:0];
        default: st_d.mask = st_q.mask;
      endcase
    end
    // Set after the clear so a same-cycle event survives
    st_d.stat = st_d.stat | events;
    if (srst) begin
      st_d.bus = MAD_BUS_IDLE;
      st_d.ctrl_sat = `MAD_CTRL_RST;
      st_d.stat = '0;
      st_d.mask = `MAD_MASK_RST;
      st_d.rdata = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  // One wait cycle per access keeps read data registered
  assign avs_waitrequest = (avs_read || avs_write) && (st_q.bus == MAD_BUS_IDLE);
  assign avs_readdata = st_q.rdata;
  assign irq = |(st_q.stat & st_q.mask);

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_out_idle;
    !out_take && !out_clr ##1 !out_clr;
  endsequence

  sequence s_out_load;
    out_take && !out_clr ##1 !out_clr;
  endsequence

  a_out_hold_still: assert property (s_out_idle |-> $stable(result))
    else $error("result changed without its clock enable");

  a_out_load_sum: assert property (s_out_load |-> result == $past(res_d))
    else $error("result does not hold the registered sum");

  a_out_clear_now: assert property (out_clr |-> result == '0 && !overflow)
    else $error("clear did not zero the result at once");

  a_unsigned_product: assert property (
    !operand_a_signed && !operand_b_signed |-> !p_raw[0][PW-1])
    else $error("unsigned operands gave a negative product");

  a_signed_a_neg: assert property (
    operand_a_signed && !operand_b_signed && a_op[0][A_W-1] && b_op[0] != '0
    |-> p_raw[0][PW-1])
    else $error("signed negative A did not give a negative product");

  a_signed_b_neg: assert property (
    operand_b_signed && !operand_a_signed && b_op[0][B_W-1] && a_op[0] != '0
    |-> p_raw[0][PW-1])
    else $error("signed negative B did not give a negative product");

  a_sat_clamp_value: assert property (
    overflow |-> result == pos_lim || result == ~pos_lim)
    else $error("overflow flagged without a saturated result");

  a_ovf_sticky_bit: assert property (
    overflow |=> st_q.stat[`MAD_STAT_OVF])
    else $error("overflow did not set its status bit");

  // Judged only across a plain load of the last unit, so a clear cannot mask it
  logic scan_take;
  assign scan_take = clock_strobe[CLK_A[2*(N-1) +: 2]] && clock_enable[CLK_A[2*(N-1) +: 2]]
                     && clock_strobe[CLK_B[2*(N-1) +: 2]] && clock_enable[CLK_B[2*(N-1) +: 2]]
                     && CLR_A[3*(N-1) +: 3] == `MAD_ACLR_NONE && CLR_B[3*(N-1) +: 3] == `MAD_ACLR_NONE;

  a_scan_chain_out: assert property (
    SCAN_EN != 0 && IN_REG_A[N-1] && IN_REG_B[N-1] && scan_take
    |=> scan_out_a == $past(a_src[N-1]) && scan_out_b == $past(b_src[N-1]))
    else $error("scan outputs do not follow the last unit");

  a_bus_one_wait: assert property (
    (avs_read || avs_write) && !avs_waitrequest |-> $past(st_q.bus) == MAD_BUS_IDLE)
    else $error("bus answered without its wait cycle");

  if (N >= 2 && FIRST_DIR == MAD_DIR_VAR) begin : g_dir_chk
    a_first_pair_dir: assert property (
      N == 2 |-> sum == (first_pair_add_sub_sel ? widen(p_op[0]) + widen(p_op[1])
                                                : widen(p_op[0]) - widen(p_op[1])))
      else $error("first pair direction not applied");
  end
endmodule // mad_top
`default_nettype wire

// file: mad_fab_model.sv
// User-logic model that packs per-unit operands onto the block's buses.
// Assumes two units of 16-bit operands, driven by the bench on clk.
`timescale 1ns/100ps
`default_nettype none
module mad_fab_model (
  input wire logic [15:0] a0,
  input wire logic [15:0] a1,
  input wire logic [15:0] b0,
  input wire logic [15:0] b1,
  output logic [31:0] op_a_bus,
  output logic [31:0] op_b_bus
);
  // Unit 0 in the low slice, so the widths add up per unit
  assign op_a_bus = {a1, a0};
  assign op_b_bus = {b1, b0};
endmodule // mad_fab_model
`default_nettype wire

// file: multiply_adder_regs_ports_tb_top.sv
// Self-checking bench for the multiply-add block: datapath and register slave.
// Assumes the default two-unit build with a variable first pair, output clear 0.
`timescale 1ns/100ps
`default_nettype none
module multiply_adder_regs_ports_tb_top import mad_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] a0 = 16'h0, a1 = 16'h0, b0 = 16'h0, b1 = 16'h0;
  logic [15:0] sc_a = 16'h5a5a, sc_b = 16'ha5a5;
  logic [31:0] op_a_bus, op_b_bus;
  logic [3:0] strobe = 4'h1, ena = 4'h1, clr = 4'h0;
  logic sa = 1'b0, sb = 1'b0, sel = 1'b1;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, result;
  logic avs_waitrequest, irq, overflow;
  logic [15:0] scan_out_a, scan_out_b;
  logic [31:0] result_c;
  logic [15:0] scan_c_a, scan_c_b;
  logic [31:0] rd;
  int n_fail = 0;
  int cmp_count = 0;

  mad_fab_model u_mad_fab_model (.a0(a0), .a1(a1), .b0(b0), .b1(b1), .op_a_bus(op_a_bus), .op_b_bus(op_b_bus));
  mad_top #(.FIRST_DIR(MAD_DIR_VAR), .OUT_CLR(3'h0)) u_mad_top (
    .clk(clk), .srst(srst), .op_a_bus(op_a_bus), .op_b_bus(op_b_bus),
    .scan_in_a(sc_a), .scan_in_b(sc_b), .clock_strobe(strobe), .clock_enable(ena),
    .async_clear(clr), .operand_a_signed(sa), .operand_b_signed(sb),
    .first_pair_add_sub_sel(sel), .result(result), .overflow(overflow),
    .scan_out_a(scan_out_a), .scan_out_b(scan_out_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));

  // Second build: both units take A and B from the shift-in path
  if (1) begin : g_chain
    mad_top #(.SRC_A(4'h3), .SRC_B(4'h3)) u_mad_top (
      .clk(clk), .srst(srst), .op_a_bus(op_a_bus), .op_b_bus(op_b_bus),
      .scan_in_a(sc_a), .scan_in_b(sc_b), .clock_strobe(strobe), .clock_enable(ena),
      .async_clear(clr), .operand_a_signed(sa), .operand_b_signed(sb),
      .first_pair_add_sub_sel(sel), .result(result_c), .overflow(),
      .scan_out_a(scan_c_a), .scan_out_b(scan_c_b), .avs_address(4'h0),
      .avs_read(1'b0), .avs_write(1'b0), .avs_writedata(32'h0),
      .avs_byteenable(4'h0), .avs_readdata(), .avs_waitrequest(), .irq());
  end

  initial begin
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Bus tasks start on an edge so no signal is driven twice in a step
  // Only the watchdog ends a wait that never sees waitrequest low
  task bus_rd(input logic [3:0] ad, output logic [31:0] d);
    @(posedge clk);
    avs_address <= ad;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task bus_wr(input logic [3:0] ad, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  function automatic logic [31:0] exp_sum(input logic [15:0] x0, x1, y0, y1, input logic s_a, s_b, s_l);
    logic signed [35:0] p0, p1;
    p0 = $signed({s_a & x0[15], x0}) * $signed({s_b & y0[15], y0});
    p1 = $signed({s_a & x1[15], x1}) * $signed({s_b & y1[15], y1});
    return s_l ? 32'(p0 + p1) : 32'(p0 - p1);
  endfunction

  // Three loads: input, product, output register
  task run_ops(input logic [15:0] x0, x1, y0, y1, input logic s_a, s_b, s_l);
    @(posedge clk);
    a0 <= x0; a1 <= x1; b0 <= y0; b1 <= y1;
    sa <= s_a; sb <= s_b; sel <= s_l;
    repeat (3) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    bus_rd(4'h0, rd); chk(rd, 32'h1, "ctrl reset");
    bus_rd(4'h8, rd); chk(rd, 32'h0, "mask reset");
    bus_rd(4'hc, rd); chk(rd, 32'h1f0f0f01, "info");
    bus_rd(4'h2, rd); chk(rd, 32'h0, "unmapped");
    bus_wr(4'h8, 32'h3, 4'h0);
    bus_rd(4'h8, rd); chk(rd, 32'h0, "mask lane off");
    bus_wr(4'hc, 32'h0, 4'hf);
    bus_rd(4'hc, rd); chk(rd, 32'h1f0f0f01, "info read only");
  endtask

  task t_case(input logic [15:0] x0, x1, y0, y1, input logic s_a, s_b, s_l, input logic lat);
    @(posedge clk);
    a0 <= x0; a1 <= x1; b0 <= y0; b1 <= y1;
    sa <= s_a; sb <= s_b; sel <= s_l;
    repeat (2) @(posedge clk);
    #1;
    if (lat) chk(result, 32'h0, "early result");
    @(posedge clk);
    #1;
    chk(result, exp_sum(x0, x1, y0, y1, s_a, s_b, s_l), "sum");
  endtask

  task t_mac;
    t_case(16'h0003, 16'h0005, 16'h0007, 16'h0002, 1'b0, 1'b0, 1'b1, 1'b1);
    t_case(16'hfffe, 16'h0004, 16'h0003, 16'h0005, 1'b1, 1'b0, 1'b1, 1'b0);
    t_case(16'hfffe, 16'h0004, 16'h0003, 16'h0005, 1'b0, 1'b0, 1'b0, 1'b0);
    t_case(16'h0002, 16'h0003, 16'hffff, 16'hfff0, 1'b1, 1'b1, 1'b0, 1'b0);
    t_case(16'h0003, 16'h0002, 16'hfffe, 16'h0004, 1'b0, 1'b1, 1'b1, 1'b0);
    t_case(16'h8000, 16'h0001, 16'h0002, 16'h0001, 1'b1, 1'b1, 1'b0, 1'b0);
    bus_rd(4'h4, rd); chk(rd & 32'h2, 32'h2, "load seen");
  endtask

  task t_scan;
    @(posedge clk);
    sc_a <= 16'h0f0f;
    sc_b <= 16'h0003;
    run_ops(16'h1111, 16'h2222, 16'h3333, 16'h4444, 1'b0, 1'b0, 1'b1);
    chk(scan_out_a, 16'h2222, "scan a");
    chk(scan_out_b, 16'h4444, "scan b");
    chk(scan_c_a, 16'h0f0f, "chain scan a");
    chk(scan_c_b, 16'h0003, "chain scan b");
    chk(result_c, exp_sum(16'h0f0f, 16'h0f0f, 16'h0003, 16'h0003, 1'b0, 1'b0, 1'b1), "chain sum");
  endtask

  // Enable low must freeze every stage on clock 0
  task t_hold;
    @(posedge clk);
    ena <= 4'h0;
    a0 <= 16'h0009;
    repeat (5) @(posedge clk);
    #1;
    chk(result, exp_sum(16'h1111, 16'h2222, 16'h3333, 16'h4444, 1'b0, 1'b0, 1'b1), "held");
    @(posedge clk);
    ena <= 4'h1;
  endtask

  task t_clr;
    @(posedge clk);
    clr <= 4'h1;
    #1;
    chk(result, 32'h0, "clear same cycle");
    @(posedge clk);
    clr <= 4'h0;
  endtask

  task t_ovf;
    run_ops(16'hffff, 16'hffff, 16'hffff, 16'hffff, 1'b0, 1'b0, 1'b1);
    chk(overflow, 32'h1, "overflow");
    chk(result, 32'h7fffffff, "saturated");
    bus_rd(4'h4, rd); chk(rd & 32'h1, 32'h1, "ovf status");
    bus_wr(4'h8, 32'h1, 4'h1);
    @(posedge clk);
    #1;
    chk(irq, 32'h1, "irq on");
    run_ops(16'h0, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0, 1'b1);
    chk(overflow, 32'h0, "overflow gone");
    bus_wr(4'h4, 32'h1, 4'h1);
    bus_rd(4'h4, rd); chk(rd & 32'h1, 32'h0, "ovf cleared");
    #1;
    chk(irq, 32'h0, "irq off");
    bus_wr(4'h0, 32'h0, 4'h1);
    run_ops(16'hffff, 16'hffff, 16'hffff, 16'hffff, 1'b0, 1'b0, 1'b1);
    chk(overflow, 32'h0, "sat off");
    chk(result, exp_sum(16'hffff, 16'hffff, 16'hffff, 16'hffff, 1'b0, 1'b0, 1'b1), "wrapped");
    bus_rd(4'h4, rd); chk(rd & 32'h1, 32'h0, "no ovf status");
    bus_wr(4'h0, 32'h1, 4'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_mac;
    t_scan;
    t_hold;
    t_clr;
    t_ovf;
    end_sim;
  end

  // About 120 cycles expected; cut off at 4000, some thirty times that
  initial begin
    #200000;
    n_fail++;
    end_sim;
  end
endmodule // multiply_adder_regs_ports_tb_top
`default_nettype wire
